// >>> core/wlp_pkg.sv
// Constants and types for the wake-up line pending logic
// Summary of operation
// - Polarity 0 falling, 1 rising edge sets pending
// - Trigger edge sets pending; high byte 15:8
// - Pending stays set until software clears it
// - Software writing 1 sets pending like hardware
// - Edge during polarity write to its byte sets no pending
// - Both selects set: interrupt and wake-up event
// - Source select only: interrupt, no wake-up event
// - Stop enable only: wake-up event, no interrupt
// - Both selects clear: legacy pin only, no wake
// - Masked line never raises interrupt or wake-up
// - Reset clears mask, polarity and pending registers
// - Six registers at indices FA to FF
// - Shared channel requests on rising combined source
// - Source select swaps legacy pin for wake lines
// - Wake event while stopped clears stop request
`default_nettype none

package wlp_pkg;

    localparam int NUM_LINES = 16;
    localparam int REG_W     = 8;
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 12;
    localparam int IDX_W     = 10;
    localparam int ARM_W     = 3;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h0F0;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 10'h0F1;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR  = 10'h0F2;
    localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h0F9;
    localparam logic [IDX_W-1:0] IDX_MASK_HI    = 10'h0FA;
    localparam logic [IDX_W-1:0] IDX_MASK_LO    = 10'h0FB;
    localparam logic [IDX_W-1:0] IDX_POL_HI     = 10'h0FC;
    localparam logic [IDX_W-1:0] IDX_POL_LO     = 10'h0FD;
    localparam logic [IDX_W-1:0] IDX_PEND_HI    = 10'h0FE;
    localparam logic [IDX_W-1:0] IDX_PEND_LO    = 10'h0FF;

    localparam logic [REG_W-1:0]     REG_RESET  = 8'h00;
    localparam logic [NUM_LINES-1:0] LINE_RESET = 16'h0000;
    localparam logic [1:0]           RESP_OKAY   = 2'h0;
    localparam logic [1:0]           RESP_SLVERR = 2'h2;

    // Control register: bit 2 stop, bit 1 source select, bit 0 stop enable
    typedef struct packed {
        logic stop_request;
        logic shared_ext_irq_channel_source_select;
        logic wake_stop_enable;
    } wlp_ctrl_type;
    localparam int CTRL_W = 3;

    // Interrupt status layout: bit 1 wake rise, bit 0 channel edge
    typedef struct packed {
        logic wake_rise;
        logic chan_edge;
    } wlp_evt_type;
    localparam int EVT_W = 2;

endpackage : wlp_pkg

`default_nettype wire

// >>> core/wlp_wakeup_pending.sv
// Wake-up line edge detection, pending, masking and register slave
//
// Local design decision: the AXI4-Lite slave port.
`default_nettype none

module wlp_wakeup_pending
    import wlp_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [DATA_W-1:0]    wdata,
    input  wire logic [DATA_W/8-1:0]  wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [DATA_W-1:0]         rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    input  wire logic [NUM_LINES-1:0] wake_line_in,
    input  wire logic                 legacy_ext_irq_pin,
    output logic                      shared_ext_irq_channel,
    output logic                      shared_ext_irq_channel_edge_request,
    output logic                      wake_event,
    output logic                      stop_request,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [NUM_LINES-1:0] line_meta_reg, line_sync_reg, line_prev_reg;
    logic                 leg_meta_reg, leg_sync_reg;
    logic [ARM_W-1:0]     arm_reg;
    logic [NUM_LINES-1:0] mask_reg, pol_reg, pend_reg;
    logic [NUM_LINES-1:0] mask_next, pol_next, pend_next, pend_sw;
    wlp_ctrl_type         ctrl_reg, ctrl_sw, ctrl_next;
    wlp_evt_type          status_reg, status_next, evt_set, evt_clr;
    logic [EVT_W-1:0]     irq_en_reg;
    logic                 chan_reg, chan_edge_reg, chan_next, wake_prev_reg;
    logic [ADDR_W-1:0]    aw_addr_reg;
    logic [REG_W-1:0]     w_data_reg;
    logic                 w_lane_reg, aw_full_reg, w_full_reg;
    logic                 bvalid_reg, rvalid_reg;
    logic [1:0]           bresp_reg, rresp_reg;
    logic [DATA_W-1:0]    rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is looked at

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_meta_reg <= LINE_RESET;
            line_sync_reg <= LINE_RESET;
            line_prev_reg <= LINE_RESET;
            leg_meta_reg  <= 1'b0;
            leg_sync_reg  <= 1'b0;
            arm_reg       <= '0;
        end else begin
            line_meta_reg <= wake_line_in;
            line_sync_reg <= line_meta_reg;
            line_prev_reg <= line_sync_reg;
            leg_meta_reg  <= legacy_ext_irq_pin;
            leg_sync_reg  <= leg_meta_reg;
            arm_reg       <= {arm_reg[ARM_W-2:0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel decode

    wire              wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire [IDX_W-1:0]  wr_idx  = aw_addr_reg[ADDR_W-1:2];
    wire              wr_ok   = wr_fire & w_lane_reg;
    wire              wr_mask_hi = wr_ok & (wr_idx == IDX_MASK_HI);
    wire              wr_mask_lo = wr_ok & (wr_idx == IDX_MASK_LO);
    wire              wr_pol_hi  = wr_ok & (wr_idx == IDX_POL_HI);
    wire              wr_pol_lo  = wr_ok & (wr_idx == IDX_POL_LO);
    wire              wr_pend_hi = wr_ok & (wr_idx == IDX_PEND_HI);
    wire              wr_pend_lo = wr_ok & (wr_idx == IDX_PEND_LO);
    wire              wr_ctrl    = wr_ok & (wr_idx == IDX_CTRL);
    wire              wr_irq_en  = wr_ok & (wr_idx == IDX_IRQ_ENABLE);
    wire              wr_irq_clr = wr_ok & (wr_idx == IDX_IRQ_CLEAR);
    wire              wr_mapped  = (wr_idx == IDX_MASK_HI) | (wr_idx == IDX_MASK_LO)
                                 | (wr_idx == IDX_POL_HI)  | (wr_idx == IDX_POL_LO)
                                 | (wr_idx == IDX_PEND_HI) | (wr_idx == IDX_PEND_LO)
                                 | (wr_idx == IDX_CTRL)    | (wr_idx == IDX_IRQ_STATUS)
                                 | (wr_idx == IDX_IRQ_ENABLE) | (wr_idx == IDX_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection; armed only once the sync chain holds real samples

    wire                 edge_armed = arm_reg[ARM_W-1];
    wire [NUM_LINES-1:0] rise_vec   = line_sync_reg & ~line_prev_reg;
    wire [NUM_LINES-1:0] fall_vec   = ~line_sync_reg & line_prev_reg;
    wire [NUM_LINES-1:0] trig_vec   = (rise_vec & pol_reg) | (fall_vec & ~pol_reg);
    // Polarity changing under an edge would make the edge ambiguous
    wire [NUM_LINES-1:0] pol_block  = {{REG_W{wr_pol_hi}}, {REG_W{wr_pol_lo}}};
    wire [NUM_LINES-1:0] hw_set_vec = trig_vec & ~pol_block & {NUM_LINES{edge_armed}};

    ////////////////////////////////////////////////////////////////////////////
    // Register next values; high byte holds lines 15:8

    assign mask_next = {wr_mask_hi ? w_data_reg : mask_reg[NUM_LINES-1:REG_W],
                        wr_mask_lo ? w_data_reg : mask_reg[REG_W-1:0]};
    assign pol_next  = {wr_pol_hi ? w_data_reg : pol_reg[NUM_LINES-1:REG_W],
                        wr_pol_lo ? w_data_reg : pol_reg[REG_W-1:0]};
    // Software value stored as written: ones set, zeros clear
    assign pend_sw   = {wr_pend_hi ? w_data_reg : pend_reg[NUM_LINES-1:REG_W],
                        wr_pend_lo ? w_data_reg : pend_reg[REG_W-1:0]};
    // Hardware set wins, so an edge during a clear is kept
    assign pend_next = pend_sw | hw_set_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Routing to the shared channel and the wake-up event

    wire [NUM_LINES-1:0] src_vec = mask_reg & pend_reg;
    wire                 any_src = |src_vec;
    // Served line dropping out dips the channel one cycle, so a line
    // still pending gives a fresh rising edge instead of a stuck level
    wire                 src_clr = |(src_vec & ~pend_next);
    // Source select picks wake lines or the legacy pin
    assign chan_next  = ctrl_reg.shared_ext_irq_channel_source_select ? (any_src & ~src_clr)
                                                     : leg_sync_reg;
    // Pure gates from flops, so it stands even with the clock stopped
    assign wake_event = ctrl_reg.wake_stop_enable & any_src;

    // Stop bit: hardware clear on wake beats any software write
    assign ctrl_sw   = wr_ctrl ? wlp_ctrl_type'(w_data_reg[CTRL_W-1:0]) : ctrl_reg;
    assign ctrl_next = '{stop_request:        ctrl_sw.stop_request & ~wake_event,
                         shared_ext_irq_channel_source_select: ctrl_sw.shared_ext_irq_channel_source_select,
                         wake_stop_enable:    ctrl_sw.wake_stop_enable};

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status; set wins over clear

    assign evt_set     = '{wake_rise: wake_event & ~wake_prev_reg, chan_edge: chan_edge_reg};
    assign evt_clr     = wr_irq_clr ? wlp_evt_type'(w_data_reg[EVT_W-1:0]) : '0;
    assign status_next = (status_reg & ~evt_clr) | evt_set;

    ////////////////////////////////////////////////////////////////////////////
    // Block state registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg      <= LINE_RESET;
            pol_reg       <= LINE_RESET;
            pend_reg      <= LINE_RESET;
            ctrl_reg      <= '0;
            status_reg    <= '0;
            irq_en_reg    <= '0;
            chan_reg      <= 1'b0;
            chan_edge_reg <= 1'b0;
            wake_prev_reg <= 1'b0;
        end else begin
            mask_reg      <= mask_next;
            pol_reg       <= pol_next;
            pend_reg      <= pend_next;
            ctrl_reg      <= ctrl_next;
            status_reg    <= status_next;
            irq_en_reg    <= wr_irq_en ? w_data_reg[EVT_W-1:0] : irq_en_reg;
            chan_reg      <= chan_next;
            chan_edge_reg <= chan_next & ~chan_reg;
            wake_prev_reg <= wake_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write address and data holding; taken in either order

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= REG_RESET;
            w_lane_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= wdata[REG_W-1:0];
                w_lane_reg <= wstrb[0];
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode; clear register and upper bits read as zero

    wire [IDX_W-1:0] rd_idx = araddr[ADDR_W-1:2];
    wire             rd_mapped = wr_idx_match_rd(rd_idx);
    wire [REG_W-1:0] rd_byte =
        (rd_idx == IDX_MASK_HI)    ? mask_reg[NUM_LINES-1:REG_W] :
        (rd_idx == IDX_MASK_LO)    ? mask_reg[REG_W-1:0] :
        (rd_idx == IDX_POL_HI)     ? pol_reg[NUM_LINES-1:REG_W] :
        (rd_idx == IDX_POL_LO)     ? pol_reg[REG_W-1:0] :
        (rd_idx == IDX_PEND_HI)    ? pend_reg[NUM_LINES-1:REG_W] :
        (rd_idx == IDX_PEND_LO)    ? pend_reg[REG_W-1:0] :
        (rd_idx == IDX_CTRL)       ? {{(REG_W-CTRL_W){1'b0}}, ctrl_reg} :
        (rd_idx == IDX_IRQ_STATUS) ? {{(REG_W-EVT_W){1'b0}}, status_reg} :
        (rd_idx == IDX_IRQ_ENABLE) ? {{(REG_W-EVT_W){1'b0}}, irq_en_reg} : REG_RESET;

    function automatic logic wr_idx_match_rd(input logic [IDX_W-1:0] idx);
        wr_idx_match_rd = (idx == IDX_MASK_HI) | (idx == IDX_MASK_LO)
                        | (idx == IDX_POL_HI)  | (idx == IDX_POL_LO)
                        | (idx == IDX_PEND_HI) | (idx == IDX_PEND_LO)
                        | (idx == IDX_CTRL)    | (idx == IDX_IRQ_STATUS)
                        | (idx == IDX_IRQ_ENABLE) | (idx == IDX_IRQ_CLEAR);
    endfunction : wr_idx_match_rd

    // One read outstanding; a held rvalid stalls the next address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
            rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = ~aw_full_reg;
    assign wready  = ~w_full_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = ~rvalid_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;
    assign shared_ext_irq_channel = chan_reg;
    assign shared_ext_irq_channel_edge_request     = chan_edge_reg;
    assign stop_request           = ctrl_reg.stop_request;
    assign irq                    = |(status_reg & irq_en_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    // Lines whose new synced level matches polarity after a change
    wire [NUM_LINES-1:0] exp_trig = (line_sync_reg ^ line_prev_reg)
                                  & ~(line_sync_reg ^ pol_reg)
                                  & {NUM_LINES{edge_armed}};
    wire no_pend_wr  = !wr_pend_hi && !wr_pend_lo;
    wire no_pol_wr   = !wr_pol_hi && !wr_pol_lo;

    sequence s_mask_lo_write;
        wr_mask_lo ##1 (mask_reg[REG_W-1:0] == $past(w_data_reg));
    endsequence

    sequence s_chan_rise;
        $rose(chan_reg) && chan_edge_reg ##1 status_reg.chan_edge;
    endsequence

    a_edge_sets_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        no_pol_wr |=> ((pend_reg & $past(exp_trig)) == $past(exp_trig)))
        else $error("trigger edge did not set pending");

    a_pend_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        no_pend_wr |=> ((pend_reg & $past(pend_reg)) == $past(pend_reg)))
        else $error("pending bit fell without a write");

    a_sw_set_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_pend_lo |=> ((pend_reg[REG_W-1:0] & $past(w_data_reg)) == $past(w_data_reg)))
        else $error("software write of one did not set pending");

    a_polwr_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_pol_lo && !wr_pend_lo) |=> (pend_reg[REG_W-1:0] == $past(pend_reg[REG_W-1:0])))
        else $error("edge during polarity write set pending");

    a_chan_route: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> (shared_ext_irq_channel == ($past(ctrl_reg.shared_ext_irq_channel_source_select)
                  ? (|($past(mask_reg) & $past(pend_reg))
                     && (($past(mask_reg) & $past(pend_reg) & pend_reg)
                         == ($past(mask_reg) & $past(pend_reg))))
                  : $past(leg_sync_reg))))
        else $error("shared channel source wrong");

    a_wake_masked: assert property (@(posedge aclk) disable iff (!aresetn)
        ((mask_reg & pend_reg) == LINE_RESET) |-> !wake_event)
        else $error("wake event without masked-in pending line");

    a_no_sources: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_reg.shared_ext_irq_channel_source_select && !ctrl_reg.wake_stop_enable)
        |-> !wake_event ##1 (shared_ext_irq_channel == $past(leg_sync_reg)))
        else $error("wake lines active with both selects clear");

    a_wake_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_reg.wake_stop_enable && !ctrl_reg.shared_ext_irq_channel_source_select && |(mask_reg & pend_reg)
         && !leg_sync_reg) |-> wake_event ##1 !shared_ext_irq_channel)
        else $error("wake-only mode misrouted");

    a_chan_edge: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(chan_reg) |-> s_chan_rise)
        else $error("channel rise gave no request");

    a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (stop_request && wake_event) |=> !stop_request)
        else $error("wake event did not clear stop request");

    a_reset_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> (mask_reg == LINE_RESET && pol_reg == LINE_RESET
                             && pend_reg == LINE_RESET))
        else $error("registers not cleared by reset");

    a_bus_mask_lo: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_mask_lo |-> s_mask_lo_write)
        else $error("mask low write misplaced");

endmodule : wlp_wakeup_pending

`default_nettype wire

// >>> tb/wlp_line_model.sv
// External wake-up and legacy interrupt lines driven from outside the block
`default_nettype none

module wlp_line_model
    import wlp_pkg::*;
(
    input  wire logic                 aclk,
    output logic [NUM_LINES-1:0] wake_line_in,
    output logic                 legacy_ext_irq_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines idle low; pins change only right after a clock edge
    initial begin
        wake_line_in       = LINE_RESET;
        legacy_ext_irq_pin = 1'h0;
    end

    // One clean level change per call, so no glitches reach the detector
    task automatic drive(input int idx, input logic v);
        @(posedge aclk);
        wake_line_in[idx] <= v;
    endtask : drive

    // Legacy pin is a plain level source
    task automatic set_legacy(input logic v);
        @(posedge aclk);
        legacy_ext_irq_pin <= v;
    endtask : set_legacy

endmodule : wlp_line_model

`default_nettype wire

// >>> tb/wlp_wakeup_pending_test.sv
// Self-checking bench for the wake-up line pending logic
`default_nettype none

module wlp_wakeup_pending_test
    import wlp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [ADDR_W-1:0]    awaddr, araddr;
    logic [DATA_W-1:0]    wdata, rdata, rd;
    logic [DATA_W/8-1:0]  wstrb;
    logic [1:0]           bresp, rresp, rs;
    logic                 awready, wready, bvalid, arready, rvalid;
    logic                 shared_ext_irq_channel, shared_ext_irq_channel_edge_request;
    logic                 wake_event, stop_request, irq, legacy_ext_irq_pin;
    logic [NUM_LINES-1:0] wake_line_in;
    int                   errors, n_checks, cycles, pulses;

    ////////////////////////////////////////////////////////////////////////
    wlp_wakeup_pending i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wake_line_in(wake_line_in), .legacy_ext_irq_pin(legacy_ext_irq_pin),
        .shared_ext_irq_channel(shared_ext_irq_channel),
        .shared_ext_irq_channel_edge_request(shared_ext_irq_channel_edge_request), .wake_event(wake_event),
        .stop_request(stop_request), .irq(irq)
    );
    wlp_line_model i_lines (
        .aclk(aclk), .wake_line_in(wake_line_in),
        .legacy_ext_irq_pin(legacy_ext_irq_pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and edge-pulse counter
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // Counted off the edge so a one-cycle pulse is never missed
    always @(negedge aclk) if (shared_ext_irq_channel_edge_request === 1'h1) pulses++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt

    // Handshakes are judged at the negedge, where values already hold to the edge
    task automatic axw(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        logic a, w, b;
        @(posedge aclk);
        awaddr  <= {idx, 2'h0};
        wdata   <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(negedge aclk);
            a  = awvalid && awready;
            w  = wvalid && wready;
            b  = bvalid && bready;
            rs = bresp;
            @(posedge aclk);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end while (!b);
        bready <= 1'h0;
    endtask : axw

    task automatic axr(input logic [IDX_W-1:0] idx);
        logic a, r;
        @(posedge aclk);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(negedge aclk);
            a  = arvalid && arready;
            r  = rvalid && rready;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'h0;
        end while (!r);
        rready <= 1'h0;
    endtask : axr

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            axr(IDX_CTRL + IDX_W'(i));
            chk(rd, 32'h0);
            chk(32'(rs), 32'(RESP_OKAY));
        end
        axr(10'h000);
        chk(32'(rs), 32'(RESP_SLVERR));
        axw(10'h000, 8'hFF);
        chk(32'(rs), 32'(RESP_SLVERR));
        $display("reset test done");
    endtask : t_reset

    // Line 3 rises on a rising setting, line 12 only counts its fall
    task automatic t_edges;
        axw(IDX_POL_LO, 8'h08);
        axw(IDX_POL_HI, 8'h00);
        i_lines.drive(12, 1'h1);
        wt(6);
        i_lines.drive(3, 1'h1);
        i_lines.drive(12, 1'h0);
        wt(6);
        axr(IDX_PEND_LO);
        chk(rd, 32'h08);
        axr(IDX_PEND_HI);
        chk(rd, 32'h10);
        i_lines.drive(3, 1'h0);
        wt(6);
        axr(IDX_PEND_LO);
        chk(rd, 32'h08);
        axw(IDX_PEND_LO, rd[7:0] & ~8'h08);
        axw(IDX_PEND_HI, 8'h00);
        axr(IDX_PEND_LO);
        chk(rd, 32'h00);
        // Line 3 edge lands in the cycle the polarity write takes effect
        i_lines.drive(3, 1'h1);
        axw(IDX_POL_LO, 8'h08);
        wt(6);
        axr(IDX_PEND_LO);
        chk(rd, 32'h00);
        $display("edge test done");
    endtask : t_edges

    // All four select settings, then the legacy pin alone
    task automatic t_select;
        logic [1:0] c;
        axw(IDX_MASK_LO, 8'h01);
        axw(IDX_PEND_LO, 8'h01);
        axr(IDX_PEND_LO);
        chk(rd, 32'h01);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            axw(IDX_CTRL, {6'h00, c});
            wt(4);
            chk(32'(shared_ext_irq_channel), 32'(c[1]));
            chk(32'(wake_event), 32'(c[0]));
        end
        axw(IDX_CTRL, 8'h00);
        i_lines.set_legacy(1'h1);
        wt(6);
        chk(32'(shared_ext_irq_channel), 32'h1);
        i_lines.set_legacy(1'h0);
        axw(IDX_CTRL, 8'h03);
        axw(IDX_MASK_LO, 8'h00);
        wt(2);
        chk(32'(shared_ext_irq_channel), 32'h0);
        chk(32'(wake_event), 32'h0);
        axw(IDX_PEND_LO, 8'h00);
        $display("select test done");
    endtask : t_select

    // Clearing one of two pending lines must give a fresh channel edge
    task automatic t_irq;
        int p;
        axw(IDX_CTRL, 8'h02);
        axw(IDX_MASK_LO, 8'h03);
        axw(IDX_IRQ_CLEAR, 8'h03);
        axw(IDX_IRQ_ENABLE, 8'h01);
        p = pulses;
        axw(IDX_PEND_LO, 8'h03);
        wt(6);
        chk(32'(pulses - p), 32'h1);
        chk(32'(irq), 32'h1);
        axw(IDX_IRQ_CLEAR, 8'h01);
        chk(32'(irq), 32'h0);
        axr(IDX_PEND_LO);
        axw(IDX_PEND_LO, rd[7:0] & ~8'h01);
        wt(6);
        chk(32'(pulses - p), 32'h2);
        axr(IDX_IRQ_STATUS);
        chk(rd, 32'h01);
        axw(IDX_IRQ_ENABLE, 8'h00);
        chk(32'(irq), 32'h0);
        axw(IDX_PEND_LO, 8'h00);
        axw(IDX_IRQ_CLEAR, 8'h03);
        $display("interrupt test done");
    endtask : t_irq

    // A wake event from line 0 drops the stop request
    task automatic t_stop;
        axw(IDX_POL_LO, 8'h01);
        axw(IDX_MASK_LO, 8'h01);
        axw(IDX_CTRL, 8'h05);
        wt(1);
        chk(32'(stop_request), 32'h1);
        i_lines.drive(0, 1'h1);
        wt(6);
        chk(32'(wake_event), 32'h1);
        chk(32'(stop_request), 32'h0);
        axr(IDX_IRQ_STATUS);
        chk(rd, 32'h02);
        $display("stop test done");
    endtask : t_stop

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // Main sequence: reset held for 12 cycles, then the scenarios
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr  = '0;
        araddr  = '0;
        wdata   = '0;
        wstrb   = 4'hF;
        aresetn = 1'h0;
        {errors, n_checks, cycles, pulses} = {32'h0, 32'h0, 32'h0, 32'h0};
        wt(12);
        aresetn <= 1'h1;
        wt(5);
        t_reset();
        t_edges();
        t_select();
        t_irq();
        t_stop();
        print_verdict();
    end

endmodule : wlp_wakeup_pending_test

`default_nettype wire
